// >>> sim/mcu_instruction_decode_timing_test.sv
module mcu_instruction_decode_timing_test
	import midt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Program table and signals
	// ----------------------------------------
	typedef struct packed {
		logic [13:0] w;
		logic [1:0] pip;
		midt_fmt_e fmt;
		midt_kind_e kind;
		logic [1:0] cyc;
		logic rd;
		logic wr;
		logic [1:0] pn;
	} midt_tv_s;
	localparam int NPROG = 26;
	localparam midt_tv_s TV_NOP = '{14'h0000, 2'h0, FMT_BYTE, K_PLAIN, 2'h1, 1'b0, 1'b0, 2'h0};
	midt_tv_s prog [0:NPROG-1];
	midt_tv_s cur;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [INSN_W-1:0] instr, instr_word, prog_word;
	logic [1:0] ptr_in_prog, prog_pip;
	logic [7:0] fetch_idx;
	midt_flags_s flag_we = '0, flag_val = '0, flags, fexp;
	midt_dec_s dec;
	logic issue, fetch_take, discard, extra_cycle, file_rd, file_wr;
	logic [PHASE_W-1:0] phase;
	int fails = 0, n_compared = 0, n_ld = 0, idx, ofs, n_disc, n_ext, n_rd, n_wr;

	always #12.5 clk = ~clk;
	assign prog_word = (fetch_idx < NPROG) ? prog[fetch_idx].w : INSN_NOP;
	assign prog_pip = (fetch_idx < NPROG) ? prog[fetch_idx].pip : 2'h0;

	midt_decode_timing u_dut (.clk(clk), .rst(rst), .instr(instr), .ptr_in_prog(ptr_in_prog),
		.flag_we(flag_we), .flag_val(flag_val), .dec(dec), .instr_word(instr_word), .issue(issue),
		.fetch_take(fetch_take), .discard(discard), .extra_cycle(extra_cycle), .phase(phase),
		.file_rd(file_rd), .file_wr(file_wr), .flags(flags));
	midt_prog_mem u_mem (.clk(clk), .rst(rst), .fetch_take(fetch_take), .prog_word(prog_word),
		.prog_pip(prog_pip), .fetch_idx(fetch_idx), .instr(instr), .ptr_in_prog(ptr_in_prog));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic put(input logic [13:0] w, input logic [1:0] pip, input midt_fmt_e f, input midt_kind_e k,
		input logic [1:0] c, input logic rd, input logic wr, input logic [1:0] pn);
		prog[n_ld] = '{w, pip, f, k, c, rd, wr, pn};
		n_ld++;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("compared=%0d fails=%0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Timing and decode monitor
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			idx = 0;
			ofs = 0;
			n_disc = 0;
			n_ext = 0;
			n_rd = 0;
			n_wr = 0;
			cur = TV_NOP;
		end else begin
			ofs = ofs + 1;
			n_disc += (discard === 1'b1);
			n_ext += (extra_cycle === 1'b1);
			n_rd += (file_rd === 1'b1);
			n_wr += (file_wr === 1'b1);
			if (file_rd === 1'b1) chk(16'(ofs), 16'h0002);
			if (file_wr === 1'b1) chk(16'(ofs), 16'h0004);
			if (ofs == 1) begin
				chk(instr_word, cur.w);
				chk(dec.fmt, cur.fmt);
				chk(dec.kind, cur.kind);
				if (cur.fmt == FMT_LITCTL) chk({dec.lit11, dec.lit8}, {cur.w[10:0], cur.w[7:0]});
				if (cur.fmt == FMT_LITCTL) chk(dec.lit9, cur.w[8:0]);
				if (cur.fmt == FMT_BIT) chk({dec.bit_num, dec.file_addr}, cur.w[9:0]);
				if (cur.fmt == FMT_BYTE && cur.w[13:7] != 7'h00) chk(dec.file_addr, cur.w[6:0]);
				if (cur.fmt == FMT_BYTE && cur.w[13:7] != 7'h00) chk(dec.dest_f, cur.w[7]);
				if (cur.pn[1]) chk(dec.ptr_num, cur.pn[0]);
				if (cur.w[13:5] == 9'h000 && cur.pn[1]) chk(dec.adj_mode, cur.w[1:0]);
			end
			if (issue === 1'b1) begin
				chk(16'(ofs), 16'(cur.cyc) * 16'h0004);
				chk(phase, 2'h3);
				chk(16'(n_disc), (cur.kind != K_PLAIN) ? 16'h0004 : 16'h0000);
				chk(16'(n_ext), (cur.cyc - 2'((cur.kind != K_PLAIN)) > 2'h1) ? 16'h0004 : 16'h0000);
				chk({n_rd[3:0], n_wr[3:0]}, {3'h0, cur.rd, 3'h0, cur.wr});
				cur = (idx < NPROG) ? prog[idx] : TV_NOP;
				idx++;
				ofs = 0;
				n_disc = 0;
				n_ext = 0;
				n_rd = 0;
				n_wr = 0;
			end
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		put(14'h07a0, 2'h0, FMT_BYTE, K_PLAIN, 2'h1, 1'b1, 1'b1, 2'h0);
		put(14'h0720, 2'h0, FMT_BYTE, K_PLAIN, 2'h1, 1'b1, 1'b0, 2'h0);
		put(14'h0bb5, 2'h0, FMT_BYTE, K_SKIP, 2'h2, 1'b1, 1'b1, 2'h0);
		put(14'h0f05, 2'h0, FMT_BYTE, K_SKIP, 2'h2, 1'b1, 1'b0, 2'h0);
		put(14'h13ff, 2'h0, FMT_BIT, K_PLAIN, 2'h1, 1'b1, 1'b1, 2'h0);
		put(14'h1991, 2'h0, FMT_BIT, K_SKIP, 2'h2, 1'b1, 1'b0, 2'h0);
		put(14'h27ff, 2'h0, FMT_LITCTL, K_CALL, 2'h2, 1'b0, 1'b0, 2'h0);
		put(14'h2923, 2'h0, FMT_LITCTL, K_BRANCH, 2'h2, 1'b0, 1'b0, 2'h0);
		put(14'h33ff, 2'h0, FMT_LITCTL, K_BRANCH, 2'h2, 1'b0, 1'b0, 2'h0);
		put(14'h345a, 2'h0, FMT_LITCTL, K_RETURN, 2'h2, 1'b0, 1'b0, 2'h0);
		put(14'h375a, 2'h0, FMT_LITCTL, K_RETURN, 2'h2, 1'b0, 1'b0, 2'h0);
		put(14'h0008, 2'h0, FMT_BYTE, K_RETURN, 2'h2, 1'b0, 1'b0, 2'h0);
		put(14'h0009, 2'h0, FMT_BYTE, K_RETURN, 2'h2, 1'b0, 1'b0, 2'h0);
		put(14'h000a, 2'h0, FMT_BYTE, K_CALL, 2'h2, 1'b0, 1'b0, 2'h0);
		put(14'h000b, 2'h0, FMT_BYTE, K_BRANCH, 2'h2, 1'b0, 1'b0, 2'h0);
		put(14'h0780, 2'h1, FMT_BYTE, K_PLAIN, 2'h2, 1'b1, 1'b1, 2'h2);
		put(14'h0701, 2'h1, FMT_BYTE, K_PLAIN, 2'h1, 1'b1, 1'b0, 2'h3);
		put(14'h001e, 2'h2, FMT_BYTE, K_PLAIN, 2'h2, 1'b1, 1'b1, 2'h3);
		put(14'h0010, 2'h0, FMT_BYTE, K_PLAIN, 2'h1, 1'b1, 1'b0, 2'h2);
		put(14'h0015, 2'h0, FMT_BYTE, K_PLAIN, 2'h1, 1'b1, 1'b0, 2'h3);
		put(14'h001a, 2'h0, FMT_BYTE, K_PLAIN, 2'h1, 1'b1, 1'b1, 2'h2);
		put(14'h001f, 2'h0, FMT_BYTE, K_PLAIN, 2'h1, 1'b1, 1'b1, 2'h3);
		put(14'h3fc5, 2'h2, FMT_LITCTL, K_PLAIN, 2'h2, 1'b1, 1'b1, 2'h3);
		put(14'h0b80, 2'h1, FMT_BYTE, K_SKIP, 2'h3, 1'b1, 1'b1, 2'h2);
		put(14'h303c, 2'h0, FMT_LITCTL, K_PLAIN, 2'h1, 1'b0, 1'b0, 2'h0);
		put(14'h0000, 2'h0, FMT_BYTE, K_PLAIN, 2'h1, 1'b0, 1'b0, 2'h0);
		repeat (8) @(negedge clk);
		rst = 1'b0;
		chk(flags, FLAGS_RESET);
		fexp = FLAGS_RESET;
		for (int i = 0; i < 5; i++) begin
			@(negedge clk);
			fexp = fexp ^ midt_flags_s'(5'h01 << i);
			flag_we = midt_flags_s'(5'h01 << i);
			flag_val = fexp;
			@(negedge clk);
			flag_we = '0;
			flag_val = ~fexp;
			chk(flags, fexp);
		end
		for (int k = 0; k < 3000 && idx <= NPROG; k++) @(negedge clk);
		if (idx <= NPROG) fails++;
		wrap_up();
	end

	initial begin
		#(25 * 5000);
		fails++;
		wrap_up();
	end
endmodule

// >>> sim/midt_prog_mem.sv
module midt_prog_mem
	import midt_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic fetch_take,
	input wire logic [INSN_W-1:0] prog_word,
	input wire logic [1:0] prog_pip,
	output logic [7:0] fetch_idx,
	output logic [INSN_W-1:0] instr,
	output logic [1:0] ptr_in_prog
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		fetch_idx = 8'h00;
		instr = INSN_NOP;
		ptr_in_prog = 2'h0;
	end
	always @(posedge clk) begin
		if (rst) begin
			fetch_idx <= 8'h00;
		end else if (fetch_take === 1'b1) begin
			fetch_idx <= fetch_idx + 8'h01;
		end
	end
	always @(negedge clk) begin
		instr <= prog_word;
		ptr_in_prog <= prog_pip;
	end
endmodule

// >>> verilog/midt_decode_timing.sv
module midt_decode_timing
	import midt_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [INSN_W-1:0] instr,
	input wire logic [1:0] ptr_in_prog,
	input wire midt_flags_s flag_we,
	input wire midt_flags_s flag_val,
	output midt_dec_s dec,
	output logic [INSN_W-1:0] instr_word,
	output logic issue,
	output logic fetch_take,
	output logic discard,
	output logic extra_cycle,
	output logic [PHASE_W-1:0] phase,
	output logic file_rd,
	output logic file_wr,
	output midt_flags_s flags
);
	// ----------------------------------------
	// Types and state
	// ----------------------------------------
	typedef enum logic [1:0] {ST_FIRST, ST_FLOW, ST_EXTRA} midt_state_e;

	midt_state_e state_r;
	midt_state_e state_nxt;
	logic [INSN_W-1:0] instr_r;
	logic [INSN_W-1:0] instr_nxt;
	midt_dec_s dec_r;
	midt_dec_s dec_nxt;
	midt_dec_s dec_in;
	logic extra_r;
	logic extra_nxt;
	midt_flags_s flags_r;
	midt_flags_s flags_nxt;
	logic cyc_end;
	logic last_cycle;
	logic load;

	// ----------------------------------------
	// Instruction cycle timing
	// ----------------------------------------
	midt_phase_gen #(
		.N_PHASES(PHASE_COUNT)
	) u_phase (
		.clk(clk),
		.rst(rst),
		.phase(phase),
		.cyc_end(cyc_end)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Whole word decoded at once
	assign dec_in = midt_decode(instr);

	// Single cycle unless flow or indirect via pointer in program memory
	always_comb begin
		unique case (state_r)
			ST_FIRST: last_cycle = !midt_two_cycle(dec_r.kind) && !extra_r;
			ST_FLOW: last_cycle = !extra_r;
			ST_EXTRA: last_cycle = 1'b1;
			default: last_cycle = 1'b1;
		endcase
	end

	assign load = cyc_end && last_cycle;

	always_comb begin
		state_nxt = state_r;
		instr_nxt = instr_r;
		dec_nxt = dec_r;
		extra_nxt = extra_r;
		if (load) begin
			instr_nxt = instr;
			dec_nxt = dec_in;
			state_nxt = ST_FIRST;
			extra_nxt = dec_in.uses_ind && ptr_in_prog[dec_in.ptr_num];
		end else if (cyc_end) begin
			unique case (state_r)
				ST_FIRST: state_nxt = midt_two_cycle(dec_r.kind) ? ST_FLOW : ST_EXTRA;
				ST_FLOW: state_nxt = ST_EXTRA;
				ST_EXTRA: state_nxt = ST_FIRST;
				default: state_nxt = ST_FIRST;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= ST_FIRST;
			instr_r <= INSN_NOP;
			dec_r <= '0;
			extra_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			instr_r <= instr_nxt;
			dec_r <= dec_nxt;
			extra_r <= extra_nxt;
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	// Flag update from execution
	always_comb begin
		flags_nxt = (flags_r & ~flag_we) | (flag_val & flag_we);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			flags_r <= FLAGS_RESET;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign dec = dec_r;
	assign instr_word = instr_r;
	assign flags = flags_r;
	assign issue = load;
	assign fetch_take = load;
	assign discard = (state_r == ST_FLOW);
	assign extra_cycle = (state_r == ST_EXTRA);
	assign file_rd = (state_r == ST_FIRST) && dec_r.uses_file && (phase == RD_PHASE);
	assign file_wr = (state_r == ST_FIRST) && dec_r.file_write && (phase == WR_PHASE);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	plain_one_a: assert property (@(posedge clk) disable iff (rst)
		issue ##1 (dec_r.kind == K_PLAIN && !extra_r) |-> !issue [*3] ##1 issue)
		else $error("plain instruction not one cycle");
	call_two_a: assert property (@(posedge clk) disable iff (rst)
		issue ##1 (dec_r.kind == K_CALL && !extra_r) |-> !issue [*7] ##1 issue)
		else $error("call not two cycles");
	return_two_a: assert property (@(posedge clk) disable iff (rst)
		issue ##1 (dec_r.kind == K_RETURN) |-> !issue [*7] ##1 issue)
		else $error("return not two cycles");
	branch_two_a: assert property (@(posedge clk) disable iff (rst)
		issue ##1 ((dec_r.kind == K_BRANCH || dec_r.kind == K_SKIP) && !extra_r) |-> !issue [*7] ##1 issue)
		else $error("branch or skip not two cycles");
	indirect_extra_a: assert property (@(posedge clk) disable iff (rst)
		issue && dec_in.uses_ind && ptr_in_prog[dec_in.ptr_num] && !midt_two_cycle(dec_in.kind)
		|=> extra_r ##0 !issue [*7] ##1 extra_cycle)
		else $error("indirect program access missed extra cycle");
	flush_cycle_a: assert property (@(posedge clk) disable iff (rst)
		$rose(discard) |-> $past(issue, 5) && !issue)
		else $error("flush cycle misplaced");
	rmw_order_a: assert property (@(posedge clk) disable iff (rst)
		file_wr |-> $past(file_rd, 2))
		else $error("file write without prior read");
	dest_route_a: assert property (@(posedge clk) disable iff (rst)
		file_wr && dec_r.fmt == FMT_BYTE && !dec_r.uses_ind |-> dec_r.dest_f)
		else $error("byte op wrote file with W destination");
	bit_field_a: assert property (@(posedge clk) disable iff (rst)
		issue && instr[13:12] == 2'h1 |=> dec_r.fmt == FMT_BIT && dec_r.bit_num == $past(instr[9:7])
		&& dec_r.file_addr == $past(instr[6:0]))
		else $error("bit format fields wrong");
	flag_reset_a: assert property (@(posedge clk) $fell(rst) |-> flags == FLAGS_RESET)
		else $error("flags not at reset value");
	flow_extra_a: assert property (@(posedge clk) disable iff (rst)
		issue && dec_in.uses_ind && ptr_in_prog[dec_in.ptr_num] && midt_two_cycle(dec_in.kind)
		|=> !issue [*8] ##1 extra_cycle [*3] ##1 (extra_cycle && issue))
		else $error("flow plus extra cycle wrong");
	issue_phase_a: assert property (@(posedge clk) disable iff (rst)
		issue |-> phase == 2'h3)
		else $error("issue outside last clock");
	rd_issue_a: assert property (@(posedge clk) disable iff (rst)
		issue ##2 dec_r.uses_file |-> file_rd)
		else $error("file operand not read");
	dest_file_a: assert property (@(posedge clk) disable iff (rst)
		issue ##4 (dec_r.fmt == FMT_BYTE && !dec_r.uses_ind && dec_r.dest_f) |-> file_wr)
		else $error("file destination not written");
	dest_w_a: assert property (@(posedge clk) disable iff (rst)
		issue ##4 (dec_r.fmt == FMT_BYTE && !dec_r.uses_ind && !dec_r.dest_f) |-> !file_wr)
		else $error("W destination wrote file");
	ptr_pair_a: assert property (@(posedge clk) disable iff (rst)
		dec_r.uses_ind |-> dec_r.file_addr == (dec_r.ptr_num ? IND1_ADDR : IND0_ADDR))
		else $error("pointer pair mismatch");
	adj_field_a: assert property (@(posedge clk) disable iff (rst)
		issue |=> dec_r.adj_mode == $past(instr[1:0]))
		else $error("pointer mode field wrong");
	lit_field_a: assert property (@(posedge clk) disable iff (rst)
		issue |=> dec_r.lit8 == $past(instr[7:0]) && dec_r.lit11 == $past(instr[10:0]))
		else $error("literal fields wrong");
	ofs_field_a: assert property (@(posedge clk) disable iff (rst)
		issue |=> dec_r.lit9 == $past(instr[8:0]))
		else $error("branch offset field wrong");
	faddr_field_a: assert property (@(posedge clk) disable iff (rst)
		issue && !instr[13] && instr[13:7] != 7'h00 |=> dec_r.file_addr == $past(instr[6:0]))
		else $error("file address field wrong");
	word_load_a: assert property (@(posedge clk) disable iff (rst)
		issue |=> instr_word == $past(instr))
		else $error("instruction word not loaded");
	word_hold_a: assert property (@(posedge clk) disable iff (rst)
		!issue |=> $stable(instr_word))
		else $error("instruction word changed without issue");
	flush_len_a: assert property (@(posedge clk) disable iff (rst)
		$rose(discard) |-> discard [*4] ##1 !discard)
		else $error("flush cycle not four clocks");
	extra_len_a: assert property (@(posedge clk) disable iff (rst)
		$rose(extra_cycle) |-> extra_cycle [*4] ##1 !extra_cycle)
		else $error("extra cycle not four clocks");
	flag_hold_a: assert property (@(posedge clk) disable iff (rst)
		flag_we == '0 |=> $stable(flags))
		else $error("flags changed without write");
	carry_load_a: assert property (@(posedge clk) disable iff (rst)
		flag_we.carry |=> flags.carry == $past(flag_val.carry))
		else $error("carry flag not written");
	call_decode_a: assert property (@(posedge clk) disable iff (rst)
		issue && (midt_match(instr, M_CALLJMP, V_CALL) || instr == V_CALL_W) |=> dec_r.kind == K_CALL)
		else $error("call not decoded");
	return_decode_a: assert property (@(posedge clk) disable iff (rst)
		issue && (instr == V_RETURN || instr == V_RET_INT || midt_match(instr, M_RETLIT, V_RETLIT))
		|=> dec_r.kind == K_RETURN)
		else $error("return not decoded");
endmodule

// >>> verilog/midt_phase_gen.sv
module midt_phase_gen
	import midt_pkg::*;
#(
	parameter int N_PHASES = PHASE_COUNT
) (
	input wire logic clk,
	input wire logic rst,
	output logic [PHASE_W-1:0] phase,
	output logic cyc_end
);
	// ----------------------------------------
	// Parameter check
	// ----------------------------------------
	if (N_PHASES != PHASE_COUNT) begin : g_bad
		$error("midt_phase_gen: phase count must be four");
	end

	// ----------------------------------------
	// Phase counter
	// ----------------------------------------
	logic [PHASE_W-1:0] phase_r;
	logic [PHASE_W-1:0] phase_nxt;

	always_comb begin
		phase_nxt = (phase_r == PHASE_W'(N_PHASES - 1)) ? '0 : phase_r + 2'h1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			phase_r <= '0;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	assign phase = phase_r;
	assign cyc_end = (phase_r == PHASE_W'(N_PHASES - 1));

	phase_wrap_a: assert property (@(posedge clk) disable iff (rst) cyc_end |=> phase_r == 2'h0)
		else $error("phase did not wrap after last clock");
	cycle_len_a: assert property (@(posedge clk) disable iff (rst) cyc_end |=> !cyc_end [*3] ##1 cyc_end)
		else $error("instruction cycle not four clocks");
endmodule

// >>> verilog/midt_pkg.sv
// Summary of operation
// - Each instruction is one 14-bit word holding opcode and all operands.
// - Opcodes fall into byte-oriented, bit-oriented and literal/control groups.
// - One instruction cycle is exactly four oscillator clocks.
// - Instructions take one cycle except calls, returns, branches, skips and indirection via a pointer in program memory.
// - Direct call and call via working register take two cycles.
// - Return, return with literal and return from interrupt take two cycles.
// - Jump, relative branch, branch by W and all skips take two cycles.
// - Indirect access with pointer in program memory adds one cycle.
// - File operands are read, modified, then written; read happens even for writes.
// - Destination bit 0 sends result to W, 1 back to the file register.
// - File address field is 7 bits, locations 0x00 to 0x7f.
// - Bit number selects one bit of the 8-bit file register.
// - Pointer number selects one of two pointer pairs, 0 or 1.
// - Pointer mode field picks pre/post increment or decrement.
// - Don't-care instruction bits never change the decode.
// - Bit format: bit number in bits 9..7, file address in bits 6..0.
// - Literals carry 8-bit immediate; call and jump carry 11-bit target.
// - Relative branch carries a 9-bit offset in its low bits.
package midt_pkg;
	// ----------------------------------------
	// Widths and timing
	// ----------------------------------------
	localparam int INSN_W = 14;
	localparam int FADDR_W = 7;
	localparam int PHASE_COUNT = 4;
	localparam int PHASE_W = 2;
	localparam int OSC_HZ = 40_000_000;
	localparam int INSN_HZ = OSC_HZ / PHASE_COUNT;
	localparam logic [PHASE_W-1:0] RD_PHASE = 2'h1;
	localparam logic [PHASE_W-1:0] WR_PHASE = 2'h3;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int F_LSB = 0;
	localparam int D_POS = 7;
	localparam int B_LSB = 7;
	localparam int ADJ_LSB = 0;
	localparam int N_POS_CTL = 2;
	localparam int N_POS_OFS = 6;
	localparam int RW_POS_CTL = 3;
	localparam int BIT_SKIP_POS = 11;

	// ----------------------------------------
	// Opcode masks and matches
	// ----------------------------------------
	localparam logic [13:0] INSN_NOP = 14'h0000;
	localparam logic [13:0] M_CTL = 14'h3f80;
	localparam logic [13:0] V_CTL = 14'h0000;
	localparam logic [13:0] M_FULL = 14'h3fff;
	localparam logic [13:0] V_RETURN = 14'h0008;
	localparam logic [13:0] V_RET_INT = 14'h0009;
	localparam logic [13:0] V_CALL_W = 14'h000a;
	localparam logic [13:0] V_BR_W = 14'h000b;
	localparam logic [13:0] M_PTRMM = 14'h3ff0;
	localparam logic [13:0] V_PTRMM = 14'h0010;
	localparam logic [13:0] M_BYTESKIP = 14'h3f00;
	localparam logic [13:0] V_DECSKIP = 14'h0b00;
	localparam logic [13:0] V_INCSKIP = 14'h0f00;
	localparam logic [13:0] M_CALLJMP = 14'h3800;
	localparam logic [13:0] V_CALL = 14'h2000;
	localparam logic [13:0] V_JUMP = 14'h2800;
	localparam logic [13:0] M_REL_BR = 14'h3e00;
	localparam logic [13:0] V_REL_BR = 14'h3200;
	localparam logic [13:0] M_RETLIT = 14'h3c00;
	localparam logic [13:0] V_RETLIT = 14'h3400;
	localparam logic [13:0] M_PTROFS = 14'h3f00;
	localparam logic [13:0] V_PTROFS = 14'h3f00;
	localparam logic [6:0] IND0_ADDR = 7'h00;
	localparam logic [6:0] IND1_ADDR = 7'h01;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {FMT_BYTE, FMT_BIT, FMT_LITCTL} midt_fmt_e;
	typedef enum logic [2:0] {K_PLAIN, K_CALL, K_RETURN, K_BRANCH, K_SKIP} midt_kind_e;
	typedef enum logic [1:0] {ADJ_PRE_INC, ADJ_PRE_DEC, ADJ_POST_INC, ADJ_POST_DEC} midt_adj_e;

	typedef struct packed {
		midt_fmt_e fmt;
		midt_kind_e kind;
		logic [FADDR_W-1:0] file_addr;
		logic dest_f;
		logic [2:0] bit_num;
		logic [7:0] lit8;
		logic [8:0] lit9;
		logic [10:0] lit11;
		logic ptr_num;
		midt_adj_e adj_mode;
		logic uses_file;
		logic uses_ind;
		logic file_write;
	} midt_dec_s;

	typedef struct packed {
		logic carry;
		logic digit_carry;
		logic zero;
		logic timeout;
		logic power_down;
	} midt_flags_s;

	localparam midt_flags_s FLAGS_RESET = '{carry: 1'b0, digit_carry: 1'b0, zero: 1'b0,
		timeout: 1'b1, power_down: 1'b1};

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic midt_match(input logic [13:0] w, input logic [13:0] m, input logic [13:0] v);
		return (w & m) == v;
	endfunction

	function automatic logic midt_two_cycle(input midt_kind_e k);
		return k != K_PLAIN;
	endfunction

	function automatic midt_dec_s midt_decode(input logic [INSN_W-1:0] w);
		midt_dec_s d;
		d = '0;
		d.file_addr = w[F_LSB +: FADDR_W];
		d.bit_num = w[B_LSB +: 3];
		d.lit8 = w[7:0];
		d.lit11 = w[10:0];
		d.lit9 = w[8:0];
		d.adj_mode = midt_adj_e'(w[ADJ_LSB +: 2]);
		if (w[13:12] == 2'h0) begin
			d.fmt = FMT_BYTE;
			if (midt_match(w, M_CTL, V_CTL)) begin
				if (midt_match(w, M_FULL, V_RETURN) || midt_match(w, M_FULL, V_RET_INT)) begin
					d.kind = K_RETURN;
				end else if (midt_match(w, M_FULL, V_CALL_W)) begin
					d.kind = K_CALL;
				end else if (midt_match(w, M_FULL, V_BR_W)) begin
					d.kind = K_BRANCH;
				end else if (midt_match(w, M_PTRMM, V_PTRMM)) begin
					d.ptr_num = w[N_POS_CTL];
					d.uses_file = 1'b1;
					d.uses_ind = 1'b1;
					d.file_write = w[RW_POS_CTL];
					d.file_addr = w[N_POS_CTL] ? IND1_ADDR : IND0_ADDR;
				end
			end else begin
				d.dest_f = w[D_POS];
				d.uses_file = 1'b1;
				d.file_write = w[D_POS];
				if (midt_match(w, M_BYTESKIP, V_DECSKIP) || midt_match(w, M_BYTESKIP, V_INCSKIP)) begin
					d.kind = K_SKIP;
				end
			end
		end else if (w[13:12] == 2'h1) begin
			d.fmt = FMT_BIT;
			d.uses_file = 1'b1;
			d.file_write = !w[BIT_SKIP_POS];
			d.dest_f = !w[BIT_SKIP_POS];
			d.kind = w[BIT_SKIP_POS] ? K_SKIP : K_PLAIN;
		end else begin
			d.fmt = FMT_LITCTL;
			if (midt_match(w, M_CALLJMP, V_CALL)) begin
				d.kind = K_CALL;
			end else if (midt_match(w, M_CALLJMP, V_JUMP) || midt_match(w, M_REL_BR, V_REL_BR)) begin
				d.kind = K_BRANCH;
			end else if (midt_match(w, M_RETLIT, V_RETLIT)) begin
				d.kind = K_RETURN;
			end else if (midt_match(w, M_PTROFS, V_PTROFS)) begin
				d.ptr_num = w[N_POS_OFS];
				d.uses_file = 1'b1;
				d.uses_ind = 1'b1;
				d.file_write = w[7];
				d.file_addr = w[N_POS_OFS] ? IND1_ADDR : IND0_ADDR;
			end
		end
		if (d.fmt != FMT_LITCTL && d.uses_file && !d.uses_ind) begin
			if (d.file_addr == IND0_ADDR || d.file_addr == IND1_ADDR) begin
				d.uses_ind = 1'b1;
				d.ptr_num = d.file_addr[0];
			end
		end
		return d;
	endfunction
endpackage
